//--- cba_consts.vh
// Purpose: Constants for the configuration register attribute bank
// Assumes: 32-bit configuration words, one core clock of 200 MHz
// Notes: One attribute per word; the map is a compact demonstration set
//
// Functional notes
// - Accept legacy and enhanced configuration accesses, decoded by bus/dev/fn
// - Own bus number comes from max bus range and socket number
// - Byte lane 0 holds the least significant byte of every field
// - Hard reset loads each non-sticky bit with its default value
// - Sticky bits keep their value across a hard reset
// - Read-only bits show hardware state; writes ignored
// - Write-only bits store nothing; a write fires a hardware event
// - Read/write bits store and return what software wrote
// - Read-clear bits return value, then clear because of the read
// - Read-clear-writable bits clear after read and accept writes
// - Write one clears the bit; write zero leaves it
// - Write zero clears the bit; write one leaves it
// - Write one sets the bit; hardware clears it later
// - Write zero sets the bit; hardware clears it later
// - Lockable bits take writes until hardware or lock control blocks
// - Write-once bits take only the first write until reset
// - Write-once protection is tracked per bit, not per field
// - Restricted field updates only on writes of supported values
// - Lock-controlled bits turn read-only once their lock bit is set
// - Reserved locations complete normally and read as zero
// - Only the power-good reset clears sticky bits
`ifndef CBA_CONSTS_VH
`define CBA_CONSTS_VH

// Word indices (byte offset / 4)
`define CBA_W_RO 10'h000
`define CBA_W_WO 10'h001
`define CBA_W_RW 10'h002
`define CBA_W_RC 10'h003
`define CBA_W_RCW 10'h004
`define CBA_W_W1C 10'h005
`define CBA_W_W0C 10'h006
`define CBA_W_W1S 10'h007
`define CBA_W_W0S 10'h008
`define CBA_W_RWL 10'h009
`define CBA_W_RWO 10'h00A
`define CBA_W_RRW 10'h00B
`define CBA_W_LCTL 10'h00C
`define CBA_W_LOCKD 10'h00D
`define CBA_W_STKY 10'h00E
`define CBA_NUM_WORDS 10'h00F

// Reset values
`define CBA_RST_RW 32'h0000_0000
`define CBA_RST_RC 32'h0000_0000
`define CBA_RST_RCW 32'h0000_0000
`define CBA_RST_W1C 32'h0000_0000
`define CBA_RST_W0C 32'h0000_0000
`define CBA_RST_W1S 32'h0000_0000
`define CBA_RST_W0S 32'h0000_0000
`define CBA_RST_RWL 32'h0000_0000
`define CBA_RST_RWO 32'h0000_0000
`define CBA_RST_RRW 32'h0000_0001
`define CBA_RST_LCTL 32'h0000_0000
`define CBA_RST_LOCKD 32'h0000_0000
`define CBA_RST_STKY 32'h0000_0000

// Field positions
`define CBA_LCTL_RWL_BIT 0
`define CBA_LCTL_LOCKD_BIT 1
`define CBA_RRW_HI 3
`define CBA_RRW_LO 0
`define CBA_LEG_EN_BIT 31
`define CBA_LEG_BUS_HI 23
`define CBA_LEG_BUS_LO 16
`define CBA_LEG_DEV_HI 15
`define CBA_LEG_DEV_LO 11
`define CBA_LEG_FN_HI 10
`define CBA_LEG_FN_LO 8
`define CBA_LEG_REG_HI 7
`define CBA_LEG_REG_LO 2
`define CBA_ENH_BUS_HI 27
`define CBA_ENH_BUS_LO 20
`define CBA_ENH_DEV_HI 19
`define CBA_ENH_DEV_LO 15
`define CBA_ENH_FN_HI 14
`define CBA_ENH_FN_LO 12
`define CBA_ENH_REG_HI 11
`define CBA_ENH_REG_LO 2

`endif

//--- cba_decode.v
// Purpose: Split a configuration address into bus, device, function, word
// Assumes: Legacy address has the enable bit; enhanced is a memory offset
// Notes: Purely combinational; legacy reach is limited to 64 words
`timescale 1ns/1ps
`include "cba_consts.vh"
module cba_decode
(
  input wire mech_i,
  input wire [31:0] addr_i,
  output reg en_o,
  output reg [7:0] bus_o,
  output reg [4:0] dev_o,
  output reg [2:0] fn_o,
  output reg [9:0] widx_o
);

  // Mechanism select: 0 legacy port pair, 1 enhanced memory map
  always @*
  begin
    if (mech_i)
    begin
      en_o = 1'b1;
      bus_o = addr_i[`CBA_ENH_BUS_HI:`CBA_ENH_BUS_LO];
      dev_o = addr_i[`CBA_ENH_DEV_HI:`CBA_ENH_DEV_LO];
      fn_o = addr_i[`CBA_ENH_FN_HI:`CBA_ENH_FN_LO];
      widx_o = addr_i[`CBA_ENH_REG_HI:`CBA_ENH_REG_LO];
    end
    else
    begin
      en_o = addr_i[`CBA_LEG_EN_BIT];
      bus_o = addr_i[`CBA_LEG_BUS_HI:`CBA_LEG_BUS_LO];
      dev_o = addr_i[`CBA_LEG_DEV_HI:`CBA_LEG_DEV_LO];
      fn_o = addr_i[`CBA_LEG_FN_HI:`CBA_LEG_FN_LO];
      widx_o = {4'h0, addr_i[`CBA_LEG_REG_HI:`CBA_LEG_REG_LO]};
    end
  end

endmodule // cba_decode

//--- cba_busnum.v
// Purpose: Work out the bus number that this device answers on
// Assumes: Strap pins are static but asynchronous to the core clock
// Notes: Own bus is the top of the bus range minus the socket number
`timescale 1ns/1ps
module cba_busnum #(
  parameter SOCK_W = 3
)
(
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] max_bus_i,
  input wire [SOCK_W-1:0] socket_i,
  output reg [7:0] own_bus_o
);

  reg [7:0] max_s1_r;
  reg [7:0] max_s2_r;
  reg [SOCK_W-1:0] sock_s1_r;
  reg [SOCK_W-1:0] sock_s2_r;

  // Two-stage synchronisers; only stage two feeds the subtraction
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      max_s1_r <= 8'h00;
      max_s2_r <= 8'h00;
      sock_s1_r <= {SOCK_W{1'b0}};
      sock_s2_r <= {SOCK_W{1'b0}};
      own_bus_o <= 8'h00;
    end
    else
    begin
      max_s1_r <= max_bus_i;
      max_s2_r <= max_s1_r;
      sock_s1_r <= socket_i;
      sock_s2_r <= sock_s1_r;
      own_bus_o <= max_s2_r - {{(8-SOCK_W){1'b0}}, sock_s2_r};
    end
  end

endmodule // cba_busnum

//--- cba_bank.v
// Purpose: Configuration register bank with per-bit access attributes
// Assumes: Requests and hardware inputs come from the core clock domain
// Notes: One access per cycle, answered on the next edge
`timescale 1ns/1ps
`include "cba_consts.vh"
module cba_bank #(
  parameter SOCK_W = 3,
  parameter [4:0] DEV_NUM = 5'h00,
  parameter [2:0] FUNC_NUM = 3'h0,
  parameter [15:0] RRW_SUPPORTED = 16'h0017
)
(
  input wire CLK_I,
  input wire RST_I,
  input wire POWER_GOOD_RESET_I,
  input wire [7:0] MAX_BUS_I,
  input wire [SOCK_W-1:0] SOCKET_I,
  input wire CFG_REQ_I,
  input wire CFG_WR_I,
  input wire CFG_MECH_I,
  input wire [31:0] CFG_ADDR_I,
  input wire [3:0] CFG_BE_I,
  input wire [31:0] CFG_WDATA_I,
  output wire CFG_ACK_O,
  output wire CFG_HIT_O,
  output wire [31:0] CFG_RDATA_O,
  input wire [31:0] HW_STATUS_I,
  input wire [31:0] HW_SET_I,
  input wire [31:0] HW_CLR_I,
  input wire HW_LOCK_I,
  output wire [31:0] WO_EVENT_O,
  output wire [7:0] OWN_BUS_O,
  output wire [32*15-1:0] REGS_O
);

  localparam NM = 14; // Words held under hard reset
  localparam [32*NM-1:0] RST_VEC = {
    `CBA_RST_LOCKD, `CBA_RST_LCTL, `CBA_RST_RRW, `CBA_RST_RWO,
    `CBA_RST_RWL, `CBA_RST_W0S, `CBA_RST_W1S, `CBA_RST_W0C,
    `CBA_RST_W1C, `CBA_RST_RCW, `CBA_RST_RC, `CBA_RST_RW,
    32'h0000_0000, 32'h0000_0000};

  // Word map, index is the dword offset:
  //  0 read-only status, no storage, writes dropped
  //  1 write-only, each written one becomes an event pulse
  //  2 plain read/write
  //  3 read-clear, a read clears only its enabled lanes
  //  4 read-clear-writable
  //  5 write-one-to-clear, 6 write-zero-to-clear
  //  7 write-one-to-set, 8 write-zero-to-set
  //  9 lockable read/write
  // 10 write-once, tracked bit by bit
  // 11 restricted-value field in bits 3:0
  // 12 lock control: bit 0 locks word 9, bit 1 locks word 13
  // 13 lock-controlled read/write
  // 14 sticky write-one-to-clear, outside the hard-reset domain
  // 15 and above reserved: claimed, read as zero, writes dropped

  // Byte enables to a bit mask; lane 0 is the least significant byte
  function [31:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Per-word access mask, zero unless this word is the target
  function [31:0] sel_mask;
    input hit;
    input [9:0] idx;
    input [9:0] w;
    input [31:0] m;
    begin
      sel_mask = (hit && (idx == w)) ? m : 32'h0000_0000;
    end
  endfunction

  // Replace masked bits of q by d
  function [31:0] merge;
    input [31:0] q;
    input [31:0] d;
    input [31:0] m;
    begin
      merge = (q & ~m) | (d & m);
    end
  endfunction

  // Decoder and bus-number results
  wire dec_en;
  wire [7:0] dec_bus;
  wire [4:0] dec_dev;
  wire [2:0] dec_fn;
  wire [9:0] widx;
  wire [7:0] own_bus;

  // Address split for both access mechanisms
  cba_decode u_decode
  (
    .mech_i(CFG_MECH_I),
    .addr_i(CFG_ADDR_I),
    .en_o(dec_en),
    .bus_o(dec_bus),
    .dev_o(dec_dev),
    .fn_o(dec_fn),
    .widx_o(widx)
  );

  // Straps are synchronised inside; valid three edges after reset
  cba_busnum #(
    .SOCK_W(SOCK_W)
  ) u_busnum
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .max_bus_i(MAX_BUS_I),
    .socket_i(SOCKET_I),
    .own_bus_o(own_bus)
  );

  // Hard-reset words, sticky word, write-once flags, answers
  reg [32*NM-1:0] mem_r;
  reg [32*NM-1:0] mem_nxt;
  reg [31:0] stky_r;
  reg [31:0] stky_nxt;
  reg [31:0] done_r;
  reg [31:0] done_nxt;
  reg [31:0] wo_r;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  reg ack_r;
  reg hit_r;

  // Claim test; no request is taken while hard reset is held
  // A half-reset bank never answers; only hardware set can still change its sticky word
  wire take = CFG_REQ_I & ~RST_I;
  wire claim = dec_en & (dec_bus == own_bus) & (dec_dev == DEV_NUM) &
    (dec_fn == FUNC_NUM);
  wire acc = take & claim & (widx < `CBA_NUM_WORDS);
  wire wr_acc = acc & CFG_WR_I;
  wire rd_acc = acc & ~CFG_WR_I;
  wire [31:0] bem = lane_mask(CFG_BE_I);
  wire [31:0] wd = CFG_WDATA_I;

  // Current word values
  wire [31:0] q_rw = mem_r[`CBA_W_RW*32 +: 32];
  wire [31:0] q_rc = mem_r[`CBA_W_RC*32 +: 32];
  wire [31:0] q_rcw = mem_r[`CBA_W_RCW*32 +: 32];
  wire [31:0] q_w1c = mem_r[`CBA_W_W1C*32 +: 32];
  wire [31:0] q_w0c = mem_r[`CBA_W_W0C*32 +: 32];
  wire [31:0] q_w1s = mem_r[`CBA_W_W1S*32 +: 32];
  wire [31:0] q_w0s = mem_r[`CBA_W_W0S*32 +: 32];
  wire [31:0] q_rwl = mem_r[`CBA_W_RWL*32 +: 32];
  wire [31:0] q_rwo = mem_r[`CBA_W_RWO*32 +: 32];
  wire [31:0] q_rrw = mem_r[`CBA_W_RRW*32 +: 32];
  wire [31:0] q_lctl = mem_r[`CBA_W_LCTL*32 +: 32];
  wire [31:0] q_lockd = mem_r[`CBA_W_LOCKD*32 +: 32];

  // Write masks, only enabled lanes of the targeted word
  wire [31:0] wm_wo = sel_mask(wr_acc, widx, `CBA_W_WO, bem);
  wire [31:0] wm_rw = sel_mask(wr_acc, widx, `CBA_W_RW, bem);
  wire [31:0] wm_rcw = sel_mask(wr_acc, widx, `CBA_W_RCW, bem);
  wire [31:0] wm_w1c = sel_mask(wr_acc, widx, `CBA_W_W1C, bem);
  wire [31:0] wm_w0c = sel_mask(wr_acc, widx, `CBA_W_W0C, bem);
  wire [31:0] wm_w1s = sel_mask(wr_acc, widx, `CBA_W_W1S, bem);
  wire [31:0] wm_w0s = sel_mask(wr_acc, widx, `CBA_W_W0S, bem);
  wire [31:0] wm_rwl = sel_mask(wr_acc, widx, `CBA_W_RWL, bem);
  wire [31:0] wm_rwo = sel_mask(wr_acc, widx, `CBA_W_RWO, bem);
  wire [31:0] wm_rrw = sel_mask(wr_acc, widx, `CBA_W_RRW, bem);
  wire [31:0] wm_lctl = sel_mask(wr_acc, widx, `CBA_W_LCTL, bem);
  wire [31:0] wm_lockd = sel_mask(wr_acc, widx, `CBA_W_LOCKD, bem);
  wire [31:0] wm_stky = sel_mask(wr_acc, widx, `CBA_W_STKY, bem);

  // Read masks; a read clears only the lanes it enabled
  wire [31:0] rm_rc = sel_mask(rd_acc, widx, `CBA_W_RC, bem);
  wire [31:0] rm_rcw = sel_mask(rd_acc, widx, `CBA_W_RCW, bem);

  // Lock terms
  wire rwl_locked = HW_LOCK_I | q_lctl[`CBA_LCTL_RWL_BIT];
  wire lockd_locked = q_lctl[`CBA_LCTL_LOCKD_BIT];
  wire [3:0] rrw_val = wd[`CBA_RRW_HI:`CBA_RRW_LO];
  wire rrw_ok = wm_rrw[`CBA_RRW_LO] & RRW_SUPPORTED[rrw_val];

  // Next values of the hard-reset words
  always @*
  begin
    mem_nxt = mem_r;
    // No storage behind read-only and write-only words
    mem_nxt[`CBA_W_RO*32 +: 32] = 32'h0000_0000;
    mem_nxt[`CBA_W_WO*32 +: 32] = 32'h0000_0000;
    mem_nxt[`CBA_W_RW*32 +: 32] = merge(q_rw, wd, wm_rw);
    // Hardware set is ORed last so it beats the clear
    mem_nxt[`CBA_W_RC*32 +: 32] = (q_rc & ~rm_rc) | HW_SET_I;
    mem_nxt[`CBA_W_RCW*32 +: 32] =
      merge(q_rcw & ~rm_rcw, wd, wm_rcw) | HW_SET_I;
    mem_nxt[`CBA_W_W1C*32 +: 32] =
      (q_w1c & ~(wm_w1c & wd)) | HW_SET_I;
    mem_nxt[`CBA_W_W0C*32 +: 32] =
      (q_w0c & ~(wm_w0c & ~wd)) | HW_SET_I;
    // A software set in the clearing cycle survives
    mem_nxt[`CBA_W_W1S*32 +: 32] =
      (q_w1s & ~HW_CLR_I) | (wm_w1s & wd);
    mem_nxt[`CBA_W_W0S*32 +: 32] =
      (q_w0s & ~HW_CLR_I) | (wm_w0s & ~wd);
    // Lock is live: clearing the control bit reopens the word
    if (!rwl_locked)
      mem_nxt[`CBA_W_RWL*32 +: 32] = merge(q_rwl, wd, wm_rwl);
    // Bits already written once are masked off individually
    mem_nxt[`CBA_W_RWO*32 +: 32] =
      merge(q_rwo, wd, wm_rwo & ~done_r);
    // Only lane 0 carries the field; a bad value drops the write
    if (rrw_ok)
      mem_nxt[`CBA_W_RRW*32 +: 32] =
        {28'h000_0000, rrw_val};
    // Lock control is itself a plain read/write word
    mem_nxt[`CBA_W_LCTL*32 +: 32] = merge(q_lctl, wd, wm_lctl);
    if (!lockd_locked)
      mem_nxt[`CBA_W_LOCKD*32 +: 32] =
        merge(q_lockd, wd, wm_lockd);
  end

  // Write-once tracking: any enabled write spends the bit
  always @*
  begin
    done_nxt = done_r | wm_rwo;
  end

  // Sticky status, write one to clear, hardware set wins
  always @*
  begin
    stky_nxt = (stky_r & ~(wm_stky & wd)) | HW_SET_I;
  end

  // Read data; pre-clear value is returned for read-clear words
  // Write cycles and unclaimed words return zero
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_acc)
    begin
      case (widx)
        `CBA_W_RO: rdata_nxt = HW_STATUS_I;
        `CBA_W_RW: rdata_nxt = q_rw;
        `CBA_W_RC: rdata_nxt = q_rc;
        `CBA_W_RCW: rdata_nxt = q_rcw;
        `CBA_W_W1C: rdata_nxt = q_w1c;
        `CBA_W_W0C: rdata_nxt = q_w0c;
        `CBA_W_W1S: rdata_nxt = q_w1s;
        `CBA_W_W0S: rdata_nxt = q_w0s;
        `CBA_W_RWL: rdata_nxt = q_rwl;
        `CBA_W_RWO: rdata_nxt = q_rwo;
        `CBA_W_RRW: rdata_nxt = q_rrw;
        `CBA_W_LCTL: rdata_nxt = q_lctl;
        `CBA_W_LOCKD: rdata_nxt = q_lockd;
        `CBA_W_STKY: rdata_nxt = stky_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Hard-reset domain: defaults on every non-sticky bit
  always @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      // Words 0 and 1 reset to zero as they hold nothing
      mem_r <= RST_VEC;
      done_r <= 32'h0000_0000;
      wo_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      hit_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      done_r <= done_nxt;
      wo_r <= wm_wo & wd;
      rdata_r <= rdata_nxt;
      ack_r <= take;
      hit_r <= take & claim;
    end
  end

  // Sticky word ignores hard reset; only power-good clears it
  // Hardware set still merges in while hard reset is held
  always @(posedge CLK_I or posedge POWER_GOOD_RESET_I)
  begin
    if (POWER_GOOD_RESET_I)
      stky_r <= `CBA_RST_STKY;
    else
      stky_r <= stky_nxt;
  end

  // Answer and state outputs, all straight from flip-flops
  // The event pulse lasts exactly one cycle after the write
  assign CFG_ACK_O = ack_r;
  assign CFG_HIT_O = hit_r;
  assign CFG_RDATA_O = rdata_r;
  assign WO_EVENT_O = wo_r;
  assign OWN_BUS_O = own_bus;
  assign REGS_O = {stky_r, mem_r};

endmodule // cba_bank

//--- cba_bank_props.sv
// Purpose: Port-level assertions for the configuration register bank
// Assumes: Checked accesses use the enhanced format, device 0, function 0
// Notes: Word index is taken from address bits 11:2
`timescale 1ns/1ps
module cba_bank_props
(
  input wire CLK_I,
  input wire RST_I,
  input wire CFG_REQ_I,
  input wire CFG_WR_I,
  input wire CFG_MECH_I,
  input wire [31:0] CFG_ADDR_I,
  input wire [3:0] CFG_BE_I,
  input wire [31:0] CFG_WDATA_I,
  input wire CFG_ACK_O,
  input wire CFG_HIT_O,
  input wire [31:0] CFG_RDATA_O,
  input wire [31:0] HW_STATUS_I,
  input wire [31:0] HW_SET_I,
  input wire [31:0] WO_EVENT_O,
  input wire [32*15-1:0] REGS_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // Request shapes; the hit flag filters out foreign addresses
  wire [9:0] ix = CFG_ADDR_I[11:2];
  wire wr_f = CFG_REQ_I & CFG_WR_I & CFG_MECH_I & (CFG_BE_I == 4'hF);
  wire rd_e = CFG_REQ_I & ~CFG_WR_I & CFG_MECH_I & (CFG_BE_I == 4'hF);
  wire done = CFG_ACK_O & CFG_HIT_O;

  a_ack_next_cycle: assert property (CFG_REQ_I |=> CFG_ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_no_request: assert property (!CFG_REQ_I |=> !CFG_ACK_O)
    else $error("ack seen without a request");
  a_rw_word_store: assert property (
    done && $past(wr_f && ix == 10'h002)
    |-> REGS_O[95:64] == $past(CFG_WDATA_I))
    else $error("read/write word did not store data");
  a_lane_only_write: assert property (
    done && $past(CFG_REQ_I && CFG_WR_I && CFG_MECH_I && ix == 10'h002
    && CFG_BE_I == 4'h1) |-> REGS_O[95:72] == $past(REGS_O[95:72])
    && REGS_O[71:64] == $past(CFG_WDATA_I[7:0]))
    else $error("byte lane write touched wrong lanes");
  a_ro_read_status: assert property (
    done && $past(rd_e && ix == 10'h000)
    |-> CFG_RDATA_O == $past(HW_STATUS_I))
    else $error("read-only word not hardware value");
  a_rsvd_read_zero: assert property (
    done && $past(rd_e && ix >= 10'h00F) |-> CFG_RDATA_O == 32'h0000_0000)
    else $error("reserved word read not zero");
  a_rc_read_clears: assert property (
    done && $past(rd_e && ix == 10'h003 && HW_SET_I == 32'h0000_0000)
    |-> REGS_O[127:96] == 32'h0000_0000)
    else $error("read-clear word not cleared by read");
  a_w1c_ones_clear: assert property (
    done && $past(wr_f && ix == 10'h005 && HW_SET_I == 32'h0000_0000)
    |-> REGS_O[191:160] == ($past(REGS_O[191:160]) & ~$past(CFG_WDATA_I)))
    else $error("write-one-to-clear result wrong");
  a_set_beats_clr: assert property (HW_SET_I[0] |=> REGS_O[160])
    else $error("hardware set lost");
  a_wo_event_pulse: assert property (
    done && $past(wr_f && ix == 10'h001) |-> WO_EVENT_O == $past(CFG_WDATA_I))
    else $error("write-only event does not match data");

  // Main scenarios reached
  c_rc_read: cover property (done && $past(rd_e && ix == 10'h003));
  c_wo_pulse: cover property (WO_EVENT_O != 32'h0000_0000);
  c_hw_win: cover property (HW_SET_I[4] && wr_f && ix == 10'h005);
endmodule // cba_bank_props

bind cba_bank cba_bank_props u_props (
  .CLK_I(CLK_I),
  .RST_I(RST_I),
  .CFG_REQ_I(CFG_REQ_I),
  .CFG_WR_I(CFG_WR_I),
  .CFG_MECH_I(CFG_MECH_I),
  .CFG_ADDR_I(CFG_ADDR_I),
  .CFG_BE_I(CFG_BE_I),
  .CFG_WDATA_I(CFG_WDATA_I),
  .CFG_ACK_O(CFG_ACK_O),
  .CFG_HIT_O(CFG_HIT_O),
  .CFG_RDATA_O(CFG_RDATA_O),
  .HW_STATUS_I(HW_STATUS_I),
  .HW_SET_I(HW_SET_I),
  .WO_EVENT_O(WO_EVENT_O),
  .REGS_O(REGS_O)
);

//--- test_cba_bank.sv
// Purpose: Directed self-checking bench for the configuration bank
// Assumes: Own bus 8'hFE from max bus 8'hFF and socket 1
// Notes: Inputs move on falling edges; results read a half cycle later
`timescale 1ns/1ps
module test_cba_bank;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg pgr = 1'b1;
  reg req = 1'b0;
  reg wr = 1'b0;
  reg mech = 1'b1;
  reg [31:0] addr = 32'h0000_0000;
  reg [3:0] be = 4'h0;
  reg [31:0] wdata = 32'h0000_0000;
  reg [31:0] hsts = 32'h5A5A_C3C3;
  reg [31:0] hset = 32'h0000_0000;
  reg [31:0] hclr = 32'h0000_0000;
  reg hlock = 1'b0;
  wire ack;
  wire hit;
  wire [31:0] rdata;
  wire [31:0] wo_ev;
  wire [7:0] own_bus;
  wire [32*15-1:0] regs;
  integer fail_count = 0;
  integer n_checks = 0;
  reg [31:0] rdv;
  reg hitv;
  reg [31:0] wov;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  cba_bank dut (
    .CLK_I(clk), .RST_I(rst), .POWER_GOOD_RESET_I(pgr),
    .MAX_BUS_I(8'hFF), .SOCKET_I(3'h1), .CFG_REQ_I(req), .CFG_WR_I(wr),
    .CFG_MECH_I(mech), .CFG_ADDR_I(addr), .CFG_BE_I(be),
    .CFG_WDATA_I(wdata), .CFG_ACK_O(ack), .CFG_HIT_O(hit),
    .CFG_RDATA_O(rdata), .HW_STATUS_I(hsts), .HW_SET_I(hset),
    .HW_CLR_I(hclr), .HW_LOCK_I(hlock), .WO_EVENT_O(wo_ev),
    .OWN_BUS_O(own_bus), .REGS_O(regs)
  );

  // Enhanced address of a word on our own bus
  function [31:0] ea(input [9:0] w);
    ea = {4'h0, 8'hFE, 5'h00, 3'h0, w, 2'h0};
  endfunction

  function [31:0] rg(input integer w);
    rg = regs[32*w +: 32];
  endfunction

  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // One access; request held across exactly one taking edge
  task acc(input w, input m, input [31:0] a, input [3:0] b, input [31:0] d);
    integer i;
    begin
      @(negedge clk);
      {req, wr, mech} = {1'b1, w, m};
      {addr, be, wdata} = {a, b, d};
      @(negedge clk);
      req = 1'b0;
      for (i = 0; i < 4 && ack !== 1'b1; i = i + 1)
        @(negedge clk);
      if (ack !== 1'b1)
      begin
        fail_count = fail_count + 1;
        $display("ERROR ack expected 1 seen %b", ack);
        conclude;
      end
      else
      begin
        rdv = rdata;
        hitv = hit;
        wov = wo_ev;
      end
    end
  endtask

  task wr_w(input [9:0] w, input [3:0] b, input [31:0] d);
    acc(1'b1, 1'b1, ea(w), b, d);
  endtask

  task rd_w(input [9:0] w);
    acc(1'b0, 1'b1, ea(w), 4'hF, 32'h0000_0000);
  endtask

  // One-cycle hardware set/clear pulse
  task hw(input [31:0] s, input [31:0] c);
    begin
      @(negedge clk);
      {hset, hclr} = {s, c};
      @(negedge clk);
      {hset, hclr} = {2{32'h0000_0000}};
    end
  endtask

  // Long enough for the strap synchroniser to settle afterwards
  task do_rst(input pg);
    begin
      @(negedge clk);
      {rst, pgr} = {1'b1, pg};
      repeat (20) @(negedge clk);
      {rst, pgr} = 2'b00;
      repeat (5) @(negedge clk);
    end
  endtask

  task t_basic;
    begin
      chk("ownbus", 32'h0000_00FE, {24'h00_0000, own_bus});
      chk("rrw", 32'h0000_0001, rg(11));
      rd_w(10'h000);
      chk("ro", hsts, rdv);
      wr_w(10'h000, 4'hF, 32'hFFFF_FFFF);
      rd_w(10'h000);
      chk("ro", hsts, rdv);
      wr_w(10'h002, 4'hF, 32'h1234_5678);
      rd_w(10'h002);
      chk("rw", 32'h1234_5678, rdv);
      wr_w(10'h002, 4'h1, 32'hAAAA_AAEE);
      chk("lane", 32'h1234_56EE, rg(2));
      wr_w(10'h001, 4'hF, 32'h8000_0001);
      chk("woev", 32'h8000_0001, wov);
      chk("wostore", 32'h0000_0000, rg(1));
      rd_w(10'h00F);
      chk("rsvd", 32'h0000_0001, {31'h0000_0000, hitv});
      chk("rsvd", 32'h0000_0000, rdv);
      acc(1'b0, 1'b0, {1'b1, 7'h00, 8'hFE, 8'h00, 6'h02, 2'h0}, 4'hF,
        32'h0000_0000);
      chk("legacy", 32'h1234_56EE, rdv);
      acc(1'b0, 1'b0, {1'b0, 7'h00, 8'hFE, 8'h00, 6'h02, 2'h0}, 4'hF,
        32'h0000_0000);
      chk("legoff", 32'h0000_0000, {31'h0000_0000, hitv});
      // Software keeps the other bytes by read, merge and write back
      rd_w(10'h002);
      wr_w(10'h002, 4'hF, {rdv[31:16], 8'h33, rdv[7:0]});
      chk("rmw", 32'h1234_33EE, rg(2));
      acc(1'b0, 1'b1, {12'h001, 20'h0_0008}, 4'hF, 32'h0000_0000);
      chk("foreign", 32'h0000_0000, {31'h0000_0000, hitv});
      $display("t_basic done");
    end
  endtask

  task t_clear;
    begin
      hw(32'h0000_0005, 32'h0000_0000);
      rd_w(10'h003);
      chk("rc", 32'h0000_0005, rdv);
      rd_w(10'h003);
      chk("rc", 32'h0000_0000, rdv);
      wr_w(10'h004, 4'hF, 32'h0000_00A5);
      rd_w(10'h004);
      chk("rcw", 32'h0000_00A5, rdv);
      rd_w(10'h004);
      chk("rcw", 32'h0000_0000, rdv);
      hw(32'h0000_00FF, 32'h0000_0000);
      wr_w(10'h005, 4'hF, 32'h0000_000F);
      chk("w1c", 32'h0000_00F0, rg(5));
      wr_w(10'h006, 4'hF, 32'hFFFF_FF0F);
      chk("w0c", 32'h0000_000F, rg(6));
      hset = 32'h0000_0010;
      wr_w(10'h005, 4'hF, 32'h0000_0010);
      hset = 32'h0000_0000;
      chk("setwin", 32'h0000_00F0, rg(5));
      $display("t_clear done");
    end
  endtask

  task t_set;
    begin
      wr_w(10'h007, 4'hF, 32'h0000_0003);
      chk("w1s", 32'h0000_0003, rg(7));
      wr_w(10'h007, 4'hF, 32'h0000_0000);
      chk("w1s", 32'h0000_0003, rg(7));
      hw(32'h0000_0000, 32'h0000_0001);
      chk("w1s", 32'h0000_0002, rg(7));
      wr_w(10'h008, 4'hF, 32'hFFFF_FFFC);
      chk("w0s", 32'h0000_0003, rg(8));
      hw(32'h0000_0000, 32'h0000_0003);
      chk("w0s", 32'h0000_0000, rg(8));
      $display("t_set done");
    end
  endtask

  task t_lock;
    begin
      wr_w(10'h009, 4'hF, 32'h0000_0011);
      hlock = 1'b1;
      wr_w(10'h009, 4'hF, 32'h0000_0022);
      hlock = 1'b0;
      chk("hwlock", 32'h0000_0011, rg(9));
      wr_w(10'h00C, 4'hF, 32'h0000_0001);
      wr_w(10'h009, 4'hF, 32'h0000_0033);
      chk("cfglock", 32'h0000_0011, rg(9));
      wr_w(10'h00D, 4'hF, 32'h0000_0005);
      wr_w(10'h00C, 4'hF, 32'h0000_0002);
      wr_w(10'h00D, 4'hF, 32'h0000_0006);
      chk("lockd", 32'h0000_0005, rg(13));
      $display("t_lock done");
    end
  endtask

  task t_once;
    begin
      wr_w(10'h00A, 4'h1, 32'h0000_0001);
      wr_w(10'h00A, 4'hF, 32'hFFFF_FFFF);
      chk("once", 32'hFFFF_FF01, rg(10));
      wr_w(10'h00B, 4'hF, 32'h0000_0002);
      chk("rrw", 32'h0000_0002, rg(11));
      wr_w(10'h00B, 4'hF, 32'h0000_0003);
      chk("rrw", 32'h0000_0002, rg(11));
      $display("t_once done");
    end
  endtask

  task t_sticky;
    begin
      wr_w(10'h00E, 4'hF, 32'h0000_000F);
      chk("stkyw1c", 32'h0000_00F0, rg(14));
      do_rst(1'b0);
      chk("sticky", 32'h0000_00F0, rg(14));
      chk("rwdef", 32'h0000_0000, rg(2));
      do_rst(1'b1);
      chk("pgclr", 32'h0000_0000, rg(14));
      $display("t_sticky done");
    end
  endtask

  // Power-up reset, then the scenarios in order
  initial
  begin
    do_rst(1'b1);
    t_basic;
    t_clear;
    t_set;
    t_lock;
    t_once;
    t_sticky;
    conclude;
  end
endmodule // test_cba_bank
